// ==== cpu_bus_write_pkg.sv ====
// Shared constants and types for the bus write sequencer and hold handshake
package cpu_bus_write_pkg;

   // =====================================================================
   // Data path geometry
   // =====================================================================
   localparam int LANES    = 4;
   localparam int BYTE_W   = 8;
   localparam int DATA_W   = LANES * BYTE_W;
   localparam int ADDR_W   = 32;
   localparam int CNT_W    = 3;              // Byte counts 0..4

   typedef logic [DATA_W-1:0] data_t;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [CNT_W-1:0]  cnt_t;
   typedef logic [LANES-1:0]  lanes_t;

   // =====================================================================
   // Bus width selection codes
   // =====================================================================
   typedef logic [1:0] width_t;
   localparam width_t WIDTH_32 = 2'h0;
   localparam width_t WIDTH_16 = 2'h1;
   localparam width_t WIDTH_8  = 2'h2;

   // Port sizes in bytes for each width
   localparam cnt_t PORT_BYTES_32 = 3'h4;
   localparam cnt_t PORT_BYTES_16 = 3'h2;
   localparam cnt_t PORT_BYTES_8  = 3'h1;

   // =====================================================================
   // Reset values
   // =====================================================================
   localparam lanes_t LANES_OFF_N  = 4'hf;   // All lane enables inactive
   localparam data_t  DATA_IDLE    = 32'h0000_0000;
   localparam addr_t  ADDR_IDLE    = 32'h0000_0000;
   localparam cnt_t   CNT_ZERO     = 3'h0;
   localparam logic   PIN_IDLE     = 1'b1;   // Active-low pins rest high

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_CYCLE,
      ST_HELD
   } seq_state_e;

endpackage

// ==== lane_mapper.sv ====
// Byte-lane mapper: enables, lane data and byte count for one write cycle
`timescale 1ns/1ps
`default_nettype none
module lane_mapper
   import cpu_bus_write_pkg::*;
(
   input  wire width_t widthSel,
   input  wire logic [1:0] addrLow,
   input  wire cnt_t   remaining,
   input  wire logic [1:0] offset,
   input  wire data_t  opData,
   output lanes_t      laneEnN,
   output data_t       laneData,
   output cnt_t        cycleBytes
);

   cnt_t       portBytes;
   cnt_t       room;
   logic [3:0] idx;
   logic [7:0] laneByte [LANES];

   // =====================================================================
   // Bytes this cycle: up to the next port-aligned boundary
   // =====================================================================
   always_comb
   begin
      unique case (widthSel)
         WIDTH_16 : portBytes = PORT_BYTES_16;
         WIDTH_8  : portBytes = PORT_BYTES_8;
         default  : portBytes = PORT_BYTES_32;   // Unused code acts as 32-bit
      endcase
      room = portBytes - (cnt_t'(addrLow) & (portBytes - 3'h1));
      cycleBytes = (remaining < room) ? remaining : room;
   end

   // =====================================================================
   // Place bytes on their own lanes, then copy down to lanes 0 and 1
   // =====================================================================
   always_comb
   begin
      laneEnN = LANES_OFF_N;
      idx     = 4'h0;
      for (int j = 0; j < LANES; j++)
      begin
         laneByte[j] = 8'h00;                   // Undefined lanes held at zero
         // Every byte still owed up to lane 3 is enabled, so a narrow port sees the rest of the word;
         // the address still advances by cycleBytes only
         if ((3'(j) >= cnt_t'(addrLow)) && (3'(j) < cnt_t'(addrLow) + remaining))
         begin
            idx = 4'(offset) + 4'(j) - 4'(addrLow);
            laneByte[j] = opData[BYTE_W*idx[1:0] +: BYTE_W];
            laneEnN[j]  = 1'b0;                  // Remaining operand lanes enabled
         end
      end
      // Lane 0 always carries the lowest byte; for addresses ending 1x lane 1 carries the lane 3 copy
      laneByte[0] = laneByte[addrLow];
      if (addrLow[1])
         laneByte[1] = laneByte[3];
      laneData = {laneByte[3], laneByte[2], laneByte[1], laneByte[0]};
   end

endmodule
`default_nettype wire

// ==== cpu_bus_write_and_hold.sv ====
// Bus write sequencer with bus hold/grant handshake
//
// Overview of operation
// - On an 8-bit bus a write takes up to four back-to-back bus cycles, one byte each.
// - A single byte at address ending 11 is copied from lane 3 to lanes 0 and 1 and written with only lane 3 enabled.
// - On grant the bus outputs are released and the grant acknowledge asserted; the master drives only after that.
// - The master releases the bus by raising its request; the acknowledge is then removed and the bus driven again.
// - The bus request is sampled once per T-state on the falling edge of the bus clock.
// - A request seen while idle between sequences is granted at once.
// - A request arriving mid-sequence is granted right after the sequence, retries included, completes.
// - The several cycles of one operand access on 8- or 16-bit buses are never split by a grant.
// - Lanes carrying neither a written byte nor its copy hold no meaningful data.
// - Each write cycle drives the address of its first byte and enables the lanes of every operand byte still owed up to lane 3 of that word.
// - On a 32-bit bus all selected bytes within one aligned word are written in one cycle.
// - On a 16-bit bus a write takes at most three cycles, the rest at the following halfword addresses.
// - In a second 16-bit cycle the remaining upper byte is copied onto lane 0.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_write_and_hold
   import cpu_bus_write_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rst,
   // Processor-side write request
   input  wire width_t busWidth,
   input  wire logic   wrReq,
   input  wire addr_t  wrAddr,
   input  wire data_t  wrData,
   input  wire cnt_t   wrBytes,
   output logic        wrReady,
   output logic        wrDone,
   // External bus
   output addr_t       busAddr,
   output data_t       busData,
   output lanes_t      byte_lane_enable_n,
   output logic        busCycle,
   output logic        busOe,
   input  wire logic   busCycleDone,
   input  wire logic   busRetry,
   // Bus hold handshake pins
   input  wire logic   bclk,
   input  wire logic   busReq_n,
   output logic        bus_grant_ack_n
);

   // =====================================================================
   // State record
   // =====================================================================
   typedef struct packed {
      seq_state_e st;
      width_t     width;
      addr_t      addr;
      data_t      opData;
      cnt_t       remaining;
      logic [1:0] offset;
      cnt_t       curBytes;
      addr_t      busAddr;
      data_t      busData;
      lanes_t     laneEnN;
      logic       busCycle;
      logic       busOe;
      logic       grantAckN;
      logic       done;
      logic [2:0] clkSync;     // Bus clock pin, three stages
      logic [2:0] reqSync;     // Bus request pin, three stages
      logic       clkFilt;
      logic       reqFiltN;
      logic       holdSeen;    // Request as sampled at the last falling edge
   } state_s;

   state_s s_reg;
   state_s s_next;

   lanes_t mapEnN;
   data_t  mapData;
   cnt_t   mapBytes;
   logic   clkFall;

   // =====================================================================
   // Lane mapping for the cycle about to be issued
   // =====================================================================
   lane_mapper mapper
   (
      .widthSel   (s_reg.width),
      .addrLow    (s_reg.addr[1:0]),
      .remaining  (s_reg.remaining),
      .offset     (s_reg.offset),
      .opData     (s_reg.opData),
      .laneEnN    (mapEnN),
      .laneData   (mapData),
      .cycleBytes (mapBytes)
   );

   // =====================================================================
   // Next-state logic
   // =====================================================================
   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;

      // Pin synchronisers: a change counts once stages two and three agree
      s_next.clkSync = {s_reg.clkSync[1:0], bclk};
      s_next.reqSync = {s_reg.reqSync[1:0], busReq_n};
      if (s_reg.clkSync[2] == s_reg.clkSync[1])
         s_next.clkFilt = s_reg.clkSync[2];
      if (s_reg.reqSync[2] == s_reg.reqSync[1])
         s_next.reqFiltN = s_reg.reqSync[2];

      // One request sample per T-state, at the bus clock's falling edge
      clkFall = s_reg.clkFilt && (s_reg.clkSync[2] == s_reg.clkSync[1]) && !s_reg.clkSync[2];
      if (clkFall)
         s_next.holdSeen = !s_reg.reqFiltN;

      unique case (s_reg.st)
         ST_IDLE :
         begin
            // Grant beats a new write when both are waiting
            if (s_reg.holdSeen)
            begin
               s_next.st        = ST_HELD;
               s_next.busOe     = 1'b0;
               s_next.grantAckN = 1'b0;
            end
            else if (wrReq && (wrBytes != CNT_ZERO))
            begin
               s_next.st        = ST_SETUP;
               s_next.width     = busWidth;
               s_next.addr      = wrAddr;
               s_next.opData    = wrData;
               s_next.remaining = wrBytes;
               s_next.offset    = 2'h0;
            end
         end
         ST_SETUP :
         begin
            // Outputs registered in the same cycle as the strobe, so lanes and strobe change together
            s_next.st       = ST_CYCLE;
            s_next.busAddr  = s_reg.addr;
            s_next.busData  = mapData;
            s_next.laneEnN  = mapEnN;
            s_next.curBytes = mapBytes;
            s_next.busCycle = 1'b1;
         end
         ST_CYCLE :
         begin
            // No hold check here: the whole sequence runs to its end
            if (busRetry)
               s_next.st = ST_CYCLE;
            else if (busCycleDone)
            begin
               s_next.busCycle  = 1'b0;
               s_next.laneEnN   = LANES_OFF_N;
               s_next.addr      = s_reg.addr + addr_t'(s_reg.curBytes);
               s_next.offset    = s_reg.offset + s_reg.curBytes[1:0];
               s_next.remaining = s_reg.remaining - s_reg.curBytes;
               if (s_reg.remaining == s_reg.curBytes)
               begin
                  s_next.st   = ST_IDLE;
                  s_next.done = 1'b1;
               end
               else
                  s_next.st = ST_SETUP;
            end
         end
         ST_HELD :
         begin
            if (!s_reg.holdSeen)
            begin
               s_next.st        = ST_IDLE;
               s_next.busOe     = 1'b1;
               s_next.grantAckN = 1'b1;
            end
         end
      endcase
   end

   // =====================================================================
   // State register
   // =====================================================================
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_reg           <= '0;
         s_reg.st        <= ST_IDLE;
         s_reg.addr      <= ADDR_IDLE;
         s_reg.opData    <= DATA_IDLE;
         s_reg.remaining <= CNT_ZERO;
         s_reg.curBytes  <= CNT_ZERO;
         s_reg.busAddr   <= ADDR_IDLE;
         s_reg.busData   <= DATA_IDLE;
         s_reg.laneEnN   <= LANES_OFF_N;
         s_reg.busOe     <= 1'b1;               // Device owns the bus by default
         s_reg.grantAckN <= PIN_IDLE;
         s_reg.clkSync   <= {3{PIN_IDLE}};
         s_reg.reqSync   <= {3{PIN_IDLE}};
         s_reg.clkFilt   <= PIN_IDLE;
         s_reg.reqFiltN  <= PIN_IDLE;
         s_reg.holdSeen  <= 1'b0;
      end
      else
         s_reg <= s_next;
   end

   // =====================================================================
   // Outputs
   // =====================================================================
   assign wrReady            = (s_reg.st == ST_IDLE) && !s_reg.holdSeen;
   assign wrDone             = s_reg.done;
   assign busAddr            = s_reg.busAddr;
   assign busData            = s_reg.busData;
   assign byte_lane_enable_n = s_reg.laneEnN;
   assign busCycle           = s_reg.busCycle;
   assign busOe              = s_reg.busOe;
   assign bus_grant_ack_n    = s_reg.grantAckN;

endmodule
`default_nettype wire

// ==== cpu_bus_write_and_hold_sva.sv ====
// Checker for the bus write sequencer and hold handshake
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_write_and_hold_sva
   import cpu_bus_write_pkg::*;
(
   input wire logic   clk,
   input wire logic   rst,
   input wire width_t busWidth,
   input wire logic   wrReq,
   input wire cnt_t   wrBytes,
   input wire logic   wrReady,
   input wire logic   wrDone,
   input wire lanes_t byte_lane_enable_n,
   input wire logic   busCycle,
   input wire logic   busOe,
   input wire logic   busCycleDone,
   input wire logic   busRetry,
   input wire logic   busReq_n,
   input wire logic   bus_grant_ack_n
);
   // ==========
   // Request idle count
   // Saturates so a long idle spell never wraps
   logic [5:0] idleCnt_reg;
   always_ff @(posedge clk)
   begin
      if (rst || !busReq_n)
         idleCnt_reg <= 6'h00;
      else if (idleCnt_reg != 6'h3f)
         idleCnt_reg <= idleCnt_reg + 6'h01;
   end
   // ==========
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence sTake;
      wrReq && wrReady && wrBytes != CNT_ZERO;
   endsequence
   sequence sGranted;
      !busOe && !wrReady && !busCycle;
   endsequence
   sequence sNextCycle;
      busCycle && bus_grant_ack_n;
   endsequence
   AST_NO_GAP_GRANT: assert property ($fell(busCycle) && !wrDone |=> sNextCycle)
      else $error("sequence split between cycles");
   AST_GRANT_FLOATS: assert property (!bus_grant_ack_n |-> sGranted)
      else $error("bus not released under grant");
   AST_GRANT_ON_REQ: assert property ($fell(bus_grant_ack_n) |-> !busReq_n)
      else $error("grant without request");
   AST_NO_SPLIT: assert property (busCycle |-> bus_grant_ack_n)
      else $error("grant inside a bus cycle");
   AST_TAKE_CYCLE: assert property (sTake |-> ##2 busCycle)
      else $error("bus cycle late after take");
   AST_DONE_CAUSE: assert property (wrDone |-> $past(busCycle) && $past(busCycleDone) && !$past(busRetry))
      else $error("done without completed cycle");
   AST_RETRY_WAITS: assert property (busCycle && busRetry |=> !wrDone)
      else $error("done after retried cycle");
   AST_LANES_IDLE: assert property (!busCycle |-> byte_lane_enable_n == LANES_OFF_N)
      else $error("lane enable outside a cycle");
   AST_ONE_CYCLE_32: assert property ($fell(busCycle) && !$past(busRetry) && busWidth == WIDTH_32 |-> wrDone)
      else $error("wide write took a second cycle");
   AST_ACK_RETURNS: assert property (idleCnt_reg >= 6'h14 |-> bus_grant_ack_n && busOe)
      else $error("grant kept without request");
   AST_RELEASE_TOGETHER: assert property ($rose(bus_grant_ack_n) |-> $rose(busOe))
      else $error("bus not retaken with ack");
endmodule
bind cpu_bus_write_and_hold cpu_bus_write_and_hold_sva cpu_bus_write_and_hold_sva_i (.clk, .rst, .busWidth,
   .wrReq, .wrBytes, .wrReady, .wrDone, .byte_lane_enable_n, .busCycle, .busOe, .busCycleDone, .busRetry,
   .busReq_n, .bus_grant_ack_n);
`default_nettype wire

// ==== bus_master_model.sv ====
// Far-side master that borrows the bus
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(parameter int HOLD_LEN = 12)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic go,
   input  wire logic bus_grant_ack_n,
   output var logic  busReq_n
);
   int useCnt;
   // Ask on go, keep asking while using the bus; request idle during reset
   always @(posedge clk)
   begin
      if (rst)
      begin
         busReq_n <= 1'b1;
         useCnt   <= 0;
      end
      else if (go && busReq_n && bus_grant_ack_n)
         busReq_n <= 1'b0;
      else if (!busReq_n && !bus_grant_ack_n)
      begin
         useCnt <= useCnt + 1;
         if (useCnt == HOLD_LEN)
            busReq_n <= 1'b1;
      end
      else
         useCnt <= 0;
   end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Testbench for the bus write sequencer and hold handshake
`timescale 1ns/1ps
`default_nettype none
module tb import cpu_bus_write_pkg::*;;
   logic   clk, rst, bclk, go, wrReq, wrReady, wrDone, busCycle, busOe;
   logic   busCycleDone, busRetry, busReq_n, bus_grant_ack_n;
   width_t busWidth;
   addr_t  wrAddr, busAddr;
   data_t  wrData, busData;
   cnt_t   wrBytes;
   lanes_t byte_lane_enable_n;
   int     err_count = 0;
   int     total_checks = 0;
   cpu_bus_write_and_hold cpu_bus_write_and_hold_i (.clk, .rst, .busWidth, .wrReq, .wrAddr, .wrData,
      .wrBytes, .wrReady, .wrDone, .busAddr, .busData, .byte_lane_enable_n, .busCycle, .busOe,
      .busCycleDone, .busRetry, .bclk, .busReq_n, .bus_grant_ack_n);
   bus_master_model bus_master_model_i (.clk, .rst, .go, .bus_grant_ack_n, .busReq_n);
   // ==========
   // Clocks; bus clock is ten system clocks, free phase
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      bclk = 1'b0;
      #7;
      forever #125 bclk = ~bclk;
   end
   // ==========
   // Shared tasks
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Request a write once idle; called at a falling edge
   task automatic start(width_t w, addr_t a, data_t d, cnt_t n);
      for (int i = 0; i < 60 && wrReady !== 1'b1; i++)
         @(negedge clk);
      busWidth = w;
      wrAddr = a;
      wrData = d;
      wrBytes = n;
      wrReq = 1'b1;
      @(negedge clk);
      wrReq = 1'b0;
   endtask
   // Judge one bus cycle, then end or retry it
   task automatic cyc(addr_t a, lanes_t en, data_t d, data_t m, logic rty, logic last);
      for (int i = 0; i < 40 && busCycle !== 1'b1; i++)
         @(negedge clk);
      check("cycle", {31'h0, busCycle}, 32'h1);
      check("addr", busAddr, a);
      check("enables", {28'h0, byte_lane_enable_n}, {28'h0, en});
      check("data", busData & m, d & m);
      busCycleDone = !rty;
      busRetry = rty;
      @(negedge clk);
      // The done pulse stands for one cycle only: judge it now
      check("done", {31'h0, wrDone}, {31'h0, last});
      busCycleDone = 1'b0;
      busRetry = 1'b0;
      @(negedge clk);
   endtask
   // Wait a bounded time for the grant pin to reach a level
   task automatic wait_ack(logic v);
      for (int i = 0; i < 60 && bus_grant_ack_n !== v; i++)
         @(negedge clk);
      check("ack", {31'h0, bus_grant_ack_n}, {31'h0, v});
      check("oe", {31'h0, busOe}, {31'h0, v});
   endtask
   // ==========
   // Scenarios
   task automatic s_narrow8();
      start(WIDTH_8, 32'h100, 32'h4433_2211, 3'h4);
      cyc(32'h100, 4'h0, 32'h4433_2211, 32'hffff_ffff, 1'b0, 1'b0);
      cyc(32'h101, 4'h1, 32'h22, 32'hff, 1'b0, 1'b0);
      cyc(32'h102, 4'h3, 32'h33, 32'hff, 1'b0, 1'b0);
      cyc(32'h103, 4'h7, 32'h44, 32'hff, 1'b0, 1'b1);
   endtask
   task automatic s_odd_byte();
      start(WIDTH_8, 32'h203, 32'ha5, 3'h1);
      cyc(32'h203, 4'h7, 32'ha500_a5a5, 32'hffff_ffff, 1'b0, 1'b1);
   endtask
   task automatic s_wide32();
      start(WIDTH_32, 32'h302, 32'hc3b2, 3'h2);
      cyc(32'h302, 4'h3, 32'hc3b2_c3b2, 32'hffff_ffff, 1'b0, 1'b1);
   endtask
   task automatic s_half16();
      start(WIDTH_16, 32'h401, 32'he1d0, 3'h2);
      cyc(32'h401, 4'h9, 32'he1_d0d0, 32'hff_ffff, 1'b0, 1'b0);
      cyc(32'h402, 4'hb, 32'he1, 32'hff, 1'b0, 1'b1);
   endtask
   task automatic s_hold_idle();
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      wait_ack(1'b0);
      check("ready", {31'h0, wrReady}, 32'h0);
      wait_ack(1'b1);
   endtask
   // Memory stalls the first cycle so the request lands mid-sequence
   task automatic s_hold_mid();
      start(WIDTH_8, 32'h500, 32'h5a69, 3'h2);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      repeat (16) @(negedge clk);
      cyc(32'h500, 4'hc, 32'h5a69, 32'hffff, 1'b1, 1'b0);
      cyc(32'h500, 4'hc, 32'h5a69, 32'hffff, 1'b0, 1'b0);
      cyc(32'h501, 4'hd, 32'h5a, 32'hff, 1'b0, 1'b1);
      wait_ack(1'b0);
      wait_ack(1'b1);
   endtask
   // ==========
   // Main sequence
   initial
   begin
      rst = 1'b1;
      go = 1'b0;
      wrReq = 1'b0;
      busWidth = WIDTH_32;
      wrAddr = ADDR_IDLE;
      wrData = DATA_IDLE;
      wrBytes = CNT_ZERO;
      busCycleDone = 1'b0;
      busRetry = 1'b0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("ackIdle", {31'h0, bus_grant_ack_n}, 32'h1);
      s_narrow8();
      s_odd_byte();
      s_wide32();
      s_half16();
      s_hold_idle();
      s_hold_mid();
      wrap_up();
   end
   // Watchdog; the run needs well under a tenth of this
   initial
   begin
      #100us;
      err_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
